// ### pkg/ldo_ctrl_regs.svh
// Register offsets, field positions, reset values and codes of the regulator control bank.
`ifndef LDO_CTRL_REGS_SVH
`define LDO_CTRL_REGS_SVH

`define OFS_GENERAL        16'h406b
`define OFS_ON_STATE       16'h406c
`define OFS_SLEEP_STATE    16'h406d
`define OFS_IRQ_STATUS     16'h4070
`define OFS_IRQ_MASK       16'h4071

`define GEN_ACTION_HI      15
`define GEN_ACTION_LO      14
`define GEN_SOURCE_HI      12
`define GEN_SOURCE_LO      11
`define GEN_VPICK          10
`define GEN_MODE_HI        9
`define GEN_MODE_LO        8
`define GEN_FLOAT          7
`define GEN_SWITCH         6
`define GEN_LPVAR          0
`define GEN_WMASK          16'hdfc1

`define SLOT_HI            15
`define SLOT_LO            13
`define STATE_MODE         8
`define VCODE_HI           4
`define VCODE_LO           0
`define STATE_WMASK        16'he11f

`define GEN_RESET          16'h0200
`define ON_RESET           16'h0000
`define SLEEP_RESET        16'h0100

`define IRQ_BIT_UV         0
`define IRQ_BIT_SHUT       1
`define IRQ_WMASK          16'h0003

`define VCODE_FINE_LAST    5'h0e
`define MV_BASE            900
`define MV_FINE_STEP       50
`define MV_COARSE_BASE     1700
`define MV_COARSE_STEP     100

`define SYNC_STAGES        3

`endif

// ### pkg/ldo_ctrl_pkg.sv
// Types shared by the regulator control bank.
package ldo_ctrl_pkg;

	typedef enum logic [1:0] {
		UV_IGNORE  = 2'h0,
		UV_SHUT_LDO = 2'h1,
		UV_SHUT_SYS = 2'h2,
		UV_RESERVED = 2'h3
	} uv_action_t;

	typedef enum logic [1:0] {
		HWC_OFF    = 2'h0,
		HWC_IN1    = 2'h1,
		HWC_IN2    = 2'h2,
		HWC_EITHER = 2'h3
	} hwc_source_t;

	typedef enum logic [1:0] {
		ST_OFF   = 2'h0,
		ST_ON    = 2'h1,
		ST_SLEEP = 2'h3,
		ST_HWC   = 2'h2
	} reg_state_t;

endpackage

// ### src/pin_sync.sv
// Three-stage synchroniser for pin inputs with an agreement filter.
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] raw,
	output logic      [WIDTH-1:0] clean
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] held;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	initial begin
		if (WIDTH < 1) begin
			$error("pin_sync needs at least one bit");
		end
	end

	// The held value changes only where the second and third stages agree.
	always_comb begin
		next_st = st;
		next_st.s1 = raw;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.held[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign clean = st.held;

endmodule

// ### src/ldo_ctrl_regs.sv
// Control register bank for one low-dropout regulator with its control decode.
//
// Contract
// - Undervoltage action 15:14: ignore, shut regulator, reset system, reserved.
// - Every undervoltage raises an interrupt whatever the action.
// - Hardware control source 12:11: off, input 1, input 2, either.
// - Under hardware control bit 10 picks ON or SLEEP voltage code.
// - Hardware mode 9:8: low power, off, low power, ON mode; reset 10.
// - Bit 7 clear discharges disabled output; set leaves it floating.
// - Bit 0 picks 50mA or 20mA low power variant everywhere.
// - ON slot 15:13: never, timeslot 1 to 5, hardware enable 1 or 2.
// - ON mode bit 8: normal or low power in ON; resets 0.
// - ON voltage code 4:0: 0.9V by 50mV to 1.6V, then 100mV steps.
// - SLEEP slot: 001-101 disable in slot 5..1; others transition 5,3,1.
// - With hardware enable, SLEEP codes 001-101 pick the sleep entry slot.
// - SLEEP mode bit 8: normal or low power in sleep; resets 1.
// - SLEEP voltage code 4:0 maps like ON code; resets zero.
`timescale 1ns/10ps
`include "ldo_ctrl_regs.svh"
module ldo_ctrl_regs
	import ldo_ctrl_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int DATA_W = 16
) (
	input  wire logic              CLK_SYS,
	input  wire logic              SRST,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [DATA_W-1:0] WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic      [DATA_W-1:0] RDATA,
	input  wire logic [2:0]        TIMESLOT,
	input  wire logic              STARTUP_PHASE,
	input  wire logic              SLEEP_PHASE,
	input  wire logic              HW_CONTROL_1,
	input  wire logic              HW_CONTROL_2,
	input  wire logic              HW_ENABLE_1,
	input  wire logic              HW_ENABLE_2,
	input  wire logic              UNDERVOLTAGE,
	output logic                   REG_ENABLE,
	output logic                   LOW_POWER,
	output logic                   LOW_POWER_20MA,
	output logic [4:0]             VOLTAGE_CODE,
	output logic [11:0]            VOLTAGE_MV,
	output logic                   DISCHARGE,
	output logic                   SWITCH_MODE,
	output logic                   SYSTEM_RESET,
	output logic                   IRQ
);

	////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [15:0] general;
		logic [15:0] on_ctl;
		logic [15:0] sleep_ctl;
		logic [15:0] irq_status;
		logic [15:0] irq_mask;
		logic        uv_prev;
		logic        uv_shut;
		reg_state_t  state;
		logic [DATA_W-1:0] rdata;
		logic        enable;
		logic        low_power;
		logic        lp20;
		logic [4:0]  vcode;
		logic [11:0] vmv;
		logic        discharge;
		logic        switch_mode;
		logic        sys_reset;
		logic        irq;
	} bank_state_t;

	bank_state_t st;
	bank_state_t next_st;
	logic [4:0]  pins;

	// Slot codes that hand the regulator to a hardware enable pin.
	localparam logic [2:0] SLOT_HWE1 = 3'h6;
	localparam logic [2:0] SLOT_HWE2 = 3'h7;

	initial begin
		if (ADDR_W < 16 || DATA_W < 16) begin
			$error("ldo_ctrl_regs needs 16-bit address and data");
		end
	end

	// Pins cross into the clock domain here; the filter costs four cycles.
	pin_sync #(
		.WIDTH(5)
	) u_sync (
		.clk  (CLK_SYS),
		.srst (SRST),
		.raw  ({UNDERVOLTAGE, HW_ENABLE_2, HW_ENABLE_1,
			HW_CONTROL_2, HW_CONTROL_1}),
		.clean(pins)
	);

	////////////////////////////////////////////////////////////////////////

	function automatic logic [11:0] code_to_mv(input logic [4:0] code);
		logic [11:0] c;
		c = {7'h00, code};
		if (code <= `VCODE_FINE_LAST) begin
			code_to_mv = 12'(`MV_BASE) + 12'(c * 12'(`MV_FINE_STEP));
		end else begin
			code_to_mv = 12'(`MV_COARSE_BASE)
				+ 12'((c - 12'h00f) * 12'(`MV_COARSE_STEP));
		end
	endfunction

	function automatic logic is_addr(input logic [ADDR_W-1:0] a,
		input logic [15:0] ofs);
		is_addr = (a == ADDR_W'(ofs));
	endfunction

	function automatic logic slot_reached(input logic phase,
		input logic [2:0] now, input logic [2:0] slot);
		slot_reached = phase && (now >= slot);
	endfunction

	// Sleep codes 001-101 count down from slot 5; the rest are transitions.
	function automatic logic [2:0] sleep_point(input logic [2:0] code);
		case (code)
			3'h0: sleep_point = 3'h5;
			3'h6: sleep_point = 3'h3;
			3'h7: sleep_point = 3'h1;
			default: sleep_point = 3'h6 - code;
		endcase
	endfunction

	function automatic logic source_active(input hwc_source_t src,
		input logic [1:0] ctl);
		case (src)
			HWC_IN1: source_active = ctl[0];
			HWC_IN2: source_active = ctl[1];
			HWC_EITHER: source_active = |ctl;
			default: source_active = 1'b0;
		endcase
	endfunction

	// Mode 01 turns it off, 11 follows the ON mode bit, others are low power.
	function automatic logic [1:0] hw_mode_out(input logic [1:0] mode,
		input logic on_mode);
		case (mode)
			2'h1: hw_mode_out = 2'b00;
			2'h3: hw_mode_out = {1'b1, on_mode};
			default: hw_mode_out = 2'b11;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////

	logic        hwc_active;
	logic        hwe_active;
	logic        hwe_assigned;
	logic        on_due;
	logic        off_due;
	logic        sleep_due;
	logic        sleep_at;
	uv_action_t  action;
	hwc_source_t source;
	logic [2:0]  on_slot;
	logic [2:0]  sleep_slot;
	logic [1:0]  hwc_mode;
	logic        uv_rise;

	always_comb begin
		next_st = st;
		action = uv_action_t'(st.general[`GEN_ACTION_HI:`GEN_ACTION_LO]);
		source = hwc_source_t'(st.general[`GEN_SOURCE_HI:`GEN_SOURCE_LO]);
		hwc_mode = st.general[`GEN_MODE_HI:`GEN_MODE_LO];
		on_slot = st.on_ctl[`SLOT_HI:`SLOT_LO];
		sleep_slot = st.sleep_ctl[`SLOT_HI:`SLOT_LO];
		uv_rise = pins[4] & ~st.uv_prev;
		next_st.uv_prev = pins[4];

		hwc_active = source_active(source, pins[1:0]);

		hwe_assigned = (on_slot == SLOT_HWE1)
			|| (on_slot == SLOT_HWE2);
		hwe_active = (on_slot == SLOT_HWE1) ? pins[2] : pins[3];
		on_due = slot_reached(STARTUP_PHASE, TIMESLOT, on_slot)
			&& (on_slot != 3'h0) && !hwe_assigned;

		// A disable code ends the ON state unless a hardware enable owns it.
		sleep_at = slot_reached(SLEEP_PHASE, TIMESLOT,
			sleep_point(sleep_slot));
		off_due = 1'b0;
		sleep_due = 1'b0;
		if (sleep_slot >= 3'h1 && sleep_slot <= 3'h5) begin
			if (hwe_assigned) begin
				sleep_due = sleep_at;
			end else begin
				off_due = sleep_at;
			end
		end else begin
			sleep_due = sleep_at;
		end

		// Hardware control overrides the slot sequencer in every state.
		case (st.state)
			ST_OFF: begin
				if (hwc_active) begin
					next_st.state = ST_HWC;
				end else if (sleep_due
					&& (on_due || hwe_assigned && hwe_active)) begin
					next_st.state = ST_SLEEP;
				end else if (on_due || (hwe_assigned && hwe_active)) begin
					next_st.state = ST_ON;
				end
			end
			ST_ON: begin
				if (hwc_active) begin
					next_st.state = ST_HWC;
				end else if (off_due || (hwe_assigned && !hwe_active)) begin
					next_st.state = ST_OFF;
				end else if (sleep_due) begin
					next_st.state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (hwc_active) begin
					next_st.state = ST_HWC;
				end else if (off_due || (hwe_assigned && !hwe_active)) begin
					next_st.state = ST_OFF;
				end else if (!SLEEP_PHASE) begin
					next_st.state = ST_ON;
				end
			end
			ST_HWC: begin
				if (!hwc_active) begin
					next_st.state = ST_ON;
				end
			end
			default: next_st.state = ST_OFF;
		endcase
		if (st.uv_shut) begin
			next_st.state = ST_OFF;
		end

		case (st.state)
			ST_ON: begin
				next_st.enable = 1'b1;
				next_st.low_power = st.on_ctl[`STATE_MODE];
				next_st.vcode = st.on_ctl[`VCODE_HI:`VCODE_LO];
			end
			ST_SLEEP: begin
				next_st.enable = 1'b1;
				next_st.low_power = st.sleep_ctl[`STATE_MODE];
				next_st.vcode = st.sleep_ctl[`VCODE_HI:`VCODE_LO];
			end
			ST_HWC: begin
				{next_st.enable, next_st.low_power} = hw_mode_out(hwc_mode,
					st.on_ctl[`STATE_MODE]);
				next_st.vcode = st.general[`GEN_VPICK]
					? st.sleep_ctl[`VCODE_HI:`VCODE_LO]
					: st.on_ctl[`VCODE_HI:`VCODE_LO];
			end
			default: begin
				next_st.enable = 1'b0;
				next_st.low_power = 1'b0;
				next_st.vcode = st.on_ctl[`VCODE_HI:`VCODE_LO];
			end
		endcase
		next_st.lp20 = st.general[`GEN_LPVAR];
		next_st.vmv = code_to_mv(next_st.vcode);
		next_st.discharge = !next_st.enable
			&& !st.general[`GEN_FLOAT];
		next_st.switch_mode = st.general[`GEN_SWITCH];
		next_st.sys_reset = uv_rise && action == UV_SHUT_SYS;

		// Bus access; the status clear loses to a new event in the same cycle.
		next_st.rdata = '0;
		if (RD) begin
			if (is_addr(ADDR, `OFS_GENERAL)) begin
				next_st.rdata = DATA_W'(st.general);
			end else if (is_addr(ADDR, `OFS_ON_STATE)) begin
				next_st.rdata = DATA_W'(st.on_ctl);
			end else if (is_addr(ADDR, `OFS_SLEEP_STATE)) begin
				next_st.rdata = DATA_W'(st.sleep_ctl);
			end else if (is_addr(ADDR, `OFS_IRQ_STATUS)) begin
				next_st.rdata = DATA_W'(st.irq_status);
				next_st.irq_status = '0;
			end else if (is_addr(ADDR, `OFS_IRQ_MASK)) begin
				next_st.rdata = DATA_W'(st.irq_mask);
			end
		end
		if (WR) begin
			if (is_addr(ADDR, `OFS_GENERAL)) begin
				next_st.general = WDATA[15:0] & `GEN_WMASK;
				next_st.uv_shut = 1'b0;
			end else if (is_addr(ADDR, `OFS_ON_STATE)) begin
				next_st.on_ctl = WDATA[15:0] & `STATE_WMASK;
			end else if (is_addr(ADDR, `OFS_SLEEP_STATE)) begin
				next_st.sleep_ctl = WDATA[15:0] & `STATE_WMASK;
			end else if (is_addr(ADDR, `OFS_IRQ_MASK)) begin
				next_st.irq_mask = WDATA[15:0] & `IRQ_WMASK;
			end
		end
		// Shutdown holds until software rewrites the general register.
		if (uv_rise && action == UV_SHUT_LDO) begin
			next_st.uv_shut = 1'b1;
		end
		if (uv_rise) begin
			next_st.irq_status[`IRQ_BIT_UV] = 1'b1;
			if (action == UV_SHUT_LDO) begin
				next_st.irq_status[`IRQ_BIT_SHUT] = 1'b1;
			end
		end
		next_st.irq = |(next_st.irq_status & st.irq_mask);
	end

	////////////////////////////////////////////////////////////////////////

	// Reset restores the defaults and leaves the output discharged.
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			st <= '0;
			st.general <= `GEN_RESET;
			st.on_ctl <= `ON_RESET;
			st.sleep_ctl <= `SLEEP_RESET;
			st.state <= ST_OFF;
			st.vmv <= 12'(`MV_BASE);
			st.discharge <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////

	assign RDATA = st.rdata;
	assign REG_ENABLE = st.enable;
	assign LOW_POWER = st.low_power;
	assign LOW_POWER_20MA = st.lp20;
	assign VOLTAGE_CODE = st.vcode;
	assign VOLTAGE_MV = st.vmv;
	assign DISCHARGE = st.discharge;
	assign SWITCH_MODE = st.switch_mode;
	assign SYSTEM_RESET = st.sys_reset;
	assign IRQ = st.irq;

endmodule

// ### testbench/ldo_ctrl_monitor.sv
// Port checks for the regulator control bank.
`timescale 1ns/10ps
module ldo_ctrl_monitor (
	input wire logic        CLK_SYS,
	input wire logic        SRST,
	input wire logic [15:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [15:0] RDATA,
	input wire logic        REG_ENABLE,
	input wire logic        LOW_POWER_20MA,
	input wire logic [4:0]  VOLTAGE_CODE,
	input wire logic [11:0] VOLTAGE_MV,
	input wire logic        DISCHARGE,
	input wire logic        SYSTEM_RESET
);
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (SRST);
	////////////////////////////////////////
	sequence s_wr_gen;
		WR && ADDR == 16'h406b;
	endsequence
	sequence s_rd_gen;
		RD && ADDR == 16'h406b;
	endsequence
	property p_rd_quiet;
		!$past(RD) |-> RDATA == 16'h0000;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet)
		else $error("read data without a read");
	property p_unmapped;
		RD && ADDR == 16'h4000 |=> RDATA == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_write_back;
		s_wr_gen ##1 s_rd_gen |=> RDATA == ($past(WDATA, 2) & 16'hdfc1);
	endproperty
	a_write_back: assert property (p_write_back)
		else $error("general readback wrong");
	// The output stage adds one cycle behind the register itself.
	property p_lp_variant;
		s_wr_gen |-> ##2 LOW_POWER_20MA == $past(WDATA[0], 2);
	endproperty
	a_lp_variant: assert property (p_lp_variant)
		else $error("low power variant wrong");
	property p_no_discharge;
		REG_ENABLE |-> !DISCHARGE;
	endproperty
	a_no_discharge: assert property (p_no_discharge)
		else $error("discharge while enabled");
	property p_mv_fine;
		VOLTAGE_CODE <= 5'h0e |->
			VOLTAGE_MV == 12'h384 + 12'h032 * VOLTAGE_CODE;
	endproperty
	a_mv_fine: assert property (p_mv_fine)
		else $error("fine step voltage wrong");
	property p_mv_coarse;
		VOLTAGE_CODE > 5'h0e |->
			VOLTAGE_MV == 12'h6a4 + 12'h064 * (VOLTAGE_CODE - 5'h0f);
	endproperty
	a_mv_coarse: assert property (p_mv_coarse)
		else $error("coarse step voltage wrong");
	property p_reset_pulse;
		SYSTEM_RESET |=> !SYSTEM_RESET;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse)
		else $error("system reset longer than a cycle");
endmodule

bind ldo_ctrl_regs ldo_ctrl_monitor mon (.CLK_SYS, .SRST, .ADDR, .WDATA,
	.WR, .RD, .RDATA, .REG_ENABLE, .LOW_POWER_20MA, .VOLTAGE_CODE,
	.VOLTAGE_MV, .DISCHARGE, .SYSTEM_RESET);

// ### testbench/tb_top.sv
// Self-checking bench for the regulator control bank.
`timescale 1ns/10ps
`include "ldo_ctrl_regs.svh"
module tb_top;
	logic        CLK_SYS, SRST, WR, RD, STARTUP_PHASE, SLEEP_PHASE;
	logic        HW_CONTROL_1, HW_CONTROL_2, HW_ENABLE_1, HW_ENABLE_2;
	logic        UNDERVOLTAGE, REG_ENABLE, LOW_POWER, LOW_POWER_20MA;
	logic        DISCHARGE, SWITCH_MODE, SYSTEM_RESET, IRQ;
	logic [15:0] ADDR, WDATA, RDATA;
	logic [2:0]  TIMESLOT;
	logic [4:0]  VOLTAGE_CODE;
	logic [11:0] VOLTAGE_MV;
	int          fail_count, total_checks;
	localparam logic [15:0] AD [4] =
		'{16'h406b, 16'h406c, 16'h406d, 16'h4071};

	ldo_ctrl_regs dut (.CLK_SYS, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA,
		.TIMESLOT, .STARTUP_PHASE, .SLEEP_PHASE, .HW_CONTROL_1,
		.HW_CONTROL_2, .HW_ENABLE_1, .HW_ENABLE_2, .UNDERVOLTAGE,
		.REG_ENABLE, .LOW_POWER, .LOW_POWER_20MA, .VOLTAGE_CODE,
		.VOLTAGE_MV, .DISCHARGE, .SWITCH_MODE, .SYSTEM_RESET, .IRQ);
	////////////////////////////////////////
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge CLK_SYS);
	endtask

	task automatic chk(input string s, input logic [15:0] e, g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask

	// The trailing gap keeps WR from being lowered and raised at one edge.
	task automatic wr(input logic [15:0] a, d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK_SYS);
		WR <= 1'b0;
		@(posedge CLK_SYS);
	endtask

	task automatic rd(input logic [15:0] a, output logic [15:0] v);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK_SYS);
		RD <= 1'b0;
		@(posedge CLK_SYS);
		v = RDATA;
	endtask

	task automatic wait_en(input logic e);
		for (int i = 0; i < 12 && REG_ENABLE !== e; i++)
			@(posedge CLK_SYS);
		chk("enable", 16'(e), 16'(REG_ENABLE));
		if (REG_ENABLE !== e)
			complete_run;
	endtask

	task automatic rst;
		{STARTUP_PHASE, SLEEP_PHASE, TIMESLOT, UNDERVOLTAGE} <= '0;
		{HW_CONTROL_1, HW_CONTROL_2, HW_ENABLE_1, HW_ENABLE_2} <= '0;
		SRST <= 1'b1;
		cyc(2);
		SRST <= 1'b0;
	endtask

	function automatic logic [11:0] mv(input int c);
		if (c <= `VCODE_FINE_LAST)
			return 12'(`MV_BASE + `MV_FINE_STEP * c);
		return 12'(`MV_COARSE_BASE + `MV_COARSE_STEP * (c - 15));
	endfunction
	////////////////////////////////////////
	task automatic t_reset;
		logic [15:0] v;
		logic [15:0] ex [4] = '{16'h0200, 16'h0000, 16'h0100, 16'h0000};
		for (int i = 0; i < 4; i++) begin
			rd(AD[i], v);
			chk("reset value", ex[i], v);
		end
		rd(16'h4070, v);
		chk("status reset", 16'h0000, v);
		chk("discharge", 16'h0001, 16'(DISCHARGE));
		chk("switch mode", 16'h0000, 16'(SWITCH_MODE));
		chk("irq idle", 16'h0000, 16'(IRQ));
		chk("millivolts", 16'(mv(0)), 16'(VOLTAGE_MV));
	endtask

	task automatic t_rw;
		logic [15:0] v;
		logic [15:0] ex [4] = '{16'hdfc1, 16'he11f, 16'he11f, 16'h0003};
		for (int i = 0; i < 4; i++) begin
			wr(AD[i], 16'hffff);
			rd(AD[i], v);
			chk("all ones", ex[i], v);
			if (i == 0) begin
				chk("switch mode", 16'h0001, 16'(SWITCH_MODE));
				chk("lp variant", 16'h0001, 16'(LOW_POWER_20MA));
			end
		end
		wr(16'h4000, 16'hffff);
		rd(16'h4000, v);
		chk("unmapped", 16'h0000, v);
		ADDR <= 16'h406b;
		WDATA <= 16'h5a5a;
		WR <= 1'b1;
		@(posedge CLK_SYS);
		WR <= 1'b0;
		RD <= 1'b1;
		@(posedge CLK_SYS);
		RD <= 1'b0;
		@(posedge CLK_SYS);
		chk("write then read", 16'h5a5a & 16'hdfc1, RDATA);
	endtask

	// The last pass leaves the event masked, so no interrupt may follow.
	task automatic t_uv;
		logic [15:0] v;
		int p;
		for (int a = 0; a < 5; a++) begin
			rst;
			wr(16'h4071, 16'(a < 4));
			wr(16'h406b, 16'(a & 3) << 14);
			UNDERVOLTAGE <= 1'b1;
			p = 0;
			repeat (8) begin
				@(posedge CLK_SYS);
				p += SYSTEM_RESET;
			end
			chk("irq", 16'(a < 4), 16'(IRQ));
			chk("sys reset", 16'(a == 2), 16'(p));
			rd(16'h4070, v);
			chk("status", {14'h0, a == 1, 1'b1}, v);
			UNDERVOLTAGE <= 1'b0;
			cyc(3);
			chk("irq clear", 16'h0000, 16'(IRQ));
		end
	endtask

	task automatic t_slot;
		for (int k = 0; k < 8; k++) begin
			rst;
			wr(16'h406c, 16'(k) << 13 | 16'(k * 4) | 16'(k % 2) << 8);
			STARTUP_PHASE <= 1'b1;
			TIMESLOT <= (k > 0 && k < 6) ? 3'(k - 1) : 3'h5;
			HW_ENABLE_1 <= k == 7;
			HW_ENABLE_2 <= k == 6;
			cyc(8);
			chk("early on", 16'h0000, 16'(REG_ENABLE));
			chk("discharge off", 16'h0001, 16'(DISCHARGE));
			if (k == 0)
				continue;
			TIMESLOT <= k < 6 ? 3'(k) : 3'h5;
			HW_ENABLE_1 <= 1'b1;
			HW_ENABLE_2 <= 1'b1;
			wait_en(1'b1);
			cyc(2);
			chk("millivolts", 16'(mv(k * 4)), 16'(VOLTAGE_MV));
			chk("on mode", 16'(k % 2), 16'(LOW_POWER));
		end
	endtask

	task automatic t_hwc;
		for (int m = 0; m < 4; m++) begin
			rst;
			wr(16'h406d, 16'h001f);
			wr(16'h406c, 16'h2003);
			wr(16'h406b, 16'h0c00 | 16'(m) << 8);
			STARTUP_PHASE <= 1'b1;
			TIMESLOT <= 3'h1;
			wait_en(1'b1);
			HW_CONTROL_1 <= 1'b1;
			cyc(8);
			chk("hwc on", 16'(m != 1), 16'(REG_ENABLE));
			if (m != 1) begin
				chk("hwc lp", 16'(m != 3), 16'(LOW_POWER));
				chk("hwc code", 16'h001f, 16'(VOLTAGE_CODE));
			end
			HW_CONTROL_1 <= 1'b0;
			cyc(1);
		end
		wr(16'h406b, 16'h1400);
		HW_CONTROL_1 <= 1'b1;
		cyc(8);
		chk("other input", 16'h0003, 16'(VOLTAGE_CODE));
		HW_CONTROL_2 <= 1'b1;
		cyc(8);
		chk("input two", 16'h001f, 16'(VOLTAGE_CODE));
	endtask

	task automatic t_sleep;
		int s;
		for (int k = 0; k < 8; k++) begin
			s = k == 0 ? 5 : k < 6 ? 6 - k : k == 6 ? 3 : 1;
			rst;
			wr(16'h406b, 16'(k % 2) << 7);
			wr(16'h406c, 16'h2003);
			wr(16'h406d, 16'(k) << 13 | 16'h0109);
			STARTUP_PHASE <= 1'b1;
			TIMESLOT <= 3'h1;
			wait_en(1'b1);
			STARTUP_PHASE <= 1'b0;
			SLEEP_PHASE <= 1'b1;
			TIMESLOT <= 3'(s - 1);
			cyc(6);
			chk("sleep early", 16'h0001, 16'(REG_ENABLE));
			chk("early code", 16'h0003, 16'(VOLTAGE_CODE));
			TIMESLOT <= 3'(s);
			wait_en(k == 0 || k > 5);
			cyc(4);
			if (k > 0 && k < 6)
				chk("float", 16'(k % 2 == 0), 16'(DISCHARGE));
			else begin
				chk("sleep code", 16'h0009, 16'(VOLTAGE_CODE));
				chk("sleep lp", 16'h0001, 16'(LOW_POWER));
			end
		end
		rst;
		wr(16'h406c, 16'hc003);
		wr(16'h406d, 16'h6109);
		HW_ENABLE_1 <= 1'b1;
		wait_en(1'b1);
		SLEEP_PHASE <= 1'b1;
		TIMESLOT <= 3'h2;
		cyc(6);
		chk("hw early code", 16'h0003, 16'(VOLTAGE_CODE));
		TIMESLOT <= 3'h3;
		cyc(6);
		chk("hw sleep code", 16'h0009, 16'(VOLTAGE_CODE));
		chk("hw sleep on", 16'h0001, 16'(REG_ENABLE));
	endtask
	////////////////////////////////////////
	initial begin
		CLK_SYS = 1'b0;
		forever #20 CLK_SYS = ~CLK_SYS;
	end

	initial begin
		fail_count = 0;
		total_checks = 0;
		{ADDR, WDATA, WR, RD, TIMESLOT, STARTUP_PHASE, SLEEP_PHASE} = '0;
		{HW_CONTROL_1, HW_CONTROL_2, HW_ENABLE_1, HW_ENABLE_2} = '0;
		UNDERVOLTAGE = 1'b0;
		SRST = 1'b1;
		repeat (16) @(posedge CLK_SYS);
		SRST <= 1'b0;
		t_reset;
		t_rw;
		t_uv;
		t_slot;
		t_hwc;
		t_sleep;
		complete_run;
	end
endmodule
